//--- tws_pkg.sv
package tws_pkg;

	// Register byte offsets on the bus
	localparam logic [4:0] TWS_OFF_CTRL = 5'h00;
	localparam logic [4:0] TWS_OFF_STAT = 5'h04;
	localparam logic [4:0] TWS_OFF_DATA = 5'h08;
	localparam logic [4:0] TWS_OFF_PDAT = 5'h0C;
	localparam logic [4:0] TWS_OFF_PCFG = 5'h10;
	localparam logic [4:0] TWS_OFF_IRQS = 5'h14;
	localparam logic [4:0] TWS_OFF_IRQM = 5'h18;
	localparam logic [4:0] TWS_OFF_PINS = 5'h1C;

	// Field positions
	localparam int TWS_CTRL_RATE0 = 0;
	localparam int TWS_CTRL_RATE1 = 1;
	localparam int TWS_CTRL_SEL   = 2;
	localparam int TWS_STAT_BUSY  = 0;
	localparam int TWS_PIN_DO     = 0;
	localparam int TWS_PIN_SK     = 1;
	localparam int TWS_PIN_DI     = 2;
	localparam int TWS_IRQ_DONE   = 0;
	localparam int TWS_BYTE0_MSB  = 7;

	// Shift register width and bits per transfer
	localparam int         TWS_SR_W  = 8;
	localparam logic [3:0] TWS_XFER  = 4'h8;
	localparam logic [3:0] TWS_CNT_1 = 4'h1;

	// Half periods of the shift clock, in core clock cycles
	localparam logic [2:0] TWS_HALF_DIV2 = 3'h1;
	localparam logic [2:0] TWS_HALF_DIV4 = 3'h2;
	localparam logic [2:0] TWS_HALF_DIV8 = 3'h4;
	localparam logic [2:0] TWS_DIV_ONE   = 3'h1;

	typedef enum logic [2:0] {
		TWS_ST_IDLE   = 3'b001,
		TWS_ST_MASTER = 3'b010,
		TWS_ST_SLAVE  = 3'b100
	} tws_state_type;

	// Pin drive bundle
	typedef struct packed {
		logic do_val;
		logic do_oe;
		logic sk_val;
		logic sk_oe;
	} tws_pins_type;

	// Complete state of the main module
	typedef struct packed {
		tws_state_type st;
		logic [2:0]    ctrl;
		logic          busy;
		logic [7:0]    sr;
		logic          so;
		logic          sck;
		logic [3:0]    cnt;
		logic          engaged;
		logic [1:0]    pdat;
		logic [1:0]    pcfg;
		logic          irq_st;
		logic          irq_mask;
		logic          ack;
		logic [31:0]   rdata;
		tws_pins_type  pins;
	} tws_regs_type;

	localparam tws_regs_type TWS_REGS_RESET = '{
		st: TWS_ST_IDLE, ctrl: 3'h0, busy: 1'b0, sr: 8'h00, so: 1'b0,
		sck: 1'b0, cnt: 4'h0, engaged: 1'b0, pdat: 2'h0, pcfg: 2'h0,
		irq_st: 1'b0, irq_mask: 1'b0, ack: 1'b0, rdata: 32'h0,
		pins: 4'h0
	};

endpackage

//--- tws_rate_div.sv
module tws_rate_div
	import tws_pkg::*;
#(
	parameter int CNT_W = 3
) (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       run_i,
	input  wire logic [1:0] rate_i,
	// Half period strobe
	output logic            tick_o
);

	initial begin
		if (CNT_W < 3)
			$error("tws_rate_div: CNT_W must hold a count of four");
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] half;

	// Half period from the rate field; 1x selects the slowest
	always_comb begin
		case (rate_i)
			2'b00:   half = CNT_W'(TWS_HALF_DIV2);
			2'b01:   half = CNT_W'(TWS_HALF_DIV4);
			default: half = CNT_W'(TWS_HALF_DIV8);
		endcase
		tick_o = run_i && (cnt_q == half - CNT_W'(TWS_DIV_ONE));
		if (!run_i || tick_o)
			cnt_d = '0;
		else
			cnt_d = cnt_q + CNT_W'(TWS_DIV_ONE);
	end

	// Counter restarts whenever the clock is stopped
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule

//--- tws_edge_det.sv
module tws_edge_det
	import tws_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Level to watch
	input  wire logic lvl_i,
	// Edge pulses
	output logic      rise_o,
	output logic      fall_o
);

	logic prev_q;

	// Edges relative to the previous cycle
	assign rise_o = lvl_i && !prev_q;
	assign fall_o = !lvl_i && prev_q;

	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			prev_q <= 1'b0;
		else
			prev_q <= lvl_i;
	end

endmodule

//--- tws_shifter.sv
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
module tws_shifter
	import tws_pkg::*;
#(
	parameter int RATE_CNT_W = 3
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Serial pins
	output logic             port_pin_data_out_o,
	output logic             port_pin_data_out_oe_o,
	input  wire logic        port_pin_shift_clk_i,
	output logic             port_pin_shift_clk_o,
	output logic             port_pin_shift_clk_oe_o,
	input  wire logic        port_pin_data_in_i,
	// Interrupt
	output logic             irq_o
);

	initial begin
		if (RATE_CNT_W < 3)
			$error("tws_shifter: RATE_CNT_W too small");
	end

	tws_regs_type r_q;
	tws_regs_type r_d;

	logic master;
	logic slave_en;
	logic clk_int;
	logic tick;
	logic rise;
	logic fall;
	logic wr_go;
	logic rd_go;
	logic wr_b0;
	logic [7:0] wb;
	logic done_ev;

	// Mode decode: clock pin config picks internal or outside clock
	assign master   = r_q.ctrl[TWS_CTRL_SEL] && r_q.pcfg[TWS_PIN_SK];
	assign slave_en = r_q.ctrl[TWS_CTRL_SEL] && !r_q.pcfg[TWS_PIN_SK];

	// Internal shift clock; slave side gated by the engaged flag, so a
	// start with the outside clock high gives an early edge
	assign clk_int = master ? r_q.sck
		: (r_q.engaged && port_pin_shift_clk_i);

	tws_rate_div #(
		.CNT_W (RATE_CNT_W)
	) u_div (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.run_i      (master && r_q.busy),
		.rate_i     (r_q.ctrl[TWS_CTRL_RATE1:TWS_CTRL_RATE0]),
		.tick_o     (tick)
	);

	tws_edge_det u_edge (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.lvl_i      (clk_int),
		.rise_o     (rise),
		.fall_o     (fall)
	);

	// Bus handshake: one wait state, write taken when ack is up, read captured while ack is low
	assign avs_waitrequest = (avs_read || avs_write) && !r_q.ack;
	assign wr_go = avs_write && r_q.ack;
	assign rd_go = avs_read && !r_q.ack;
	assign wr_b0 = wr_go && avs_byteenable[0];
	assign wb    = avs_writedata[TWS_BYTE0_MSB:0];

	// Transfer completes on the falling edge after the eighth rise
	assign done_ev = fall && r_q.busy && (r_q.cnt == TWS_XFER);

	// Outputs straight from flip-flops; irq is the AND of two
	assign avs_readdata            = r_q.rdata;
	assign port_pin_data_out_o     = r_q.pins.do_val;
	assign port_pin_data_out_oe_o  = r_q.pins.do_oe;
	assign port_pin_shift_clk_o    = r_q.pins.sk_val;
	assign port_pin_shift_clk_oe_o = r_q.pins.sk_oe;
	assign irq_o = r_q.irq_st && r_q.irq_mask;

	// Next state of the whole block
	always_comb begin
		r_d = r_q;
		r_d.ack = (avs_read || avs_write) && !r_q.ack;

		// Master clock toggles each half period while busy
		if (master && r_q.busy && tick)
			r_d.sck = !r_q.sck;
		else if (!(master && r_q.busy))
			r_d.sck = 1'b0; // Stop leaves the clock low

		// Rising edge: sample data in, MSB leaves first
		if (rise) begin
			r_d.sr = {r_q.sr[TWS_SR_W-2:0], port_pin_data_in_i};
			if (r_q.busy)
				r_d.cnt = r_q.cnt + TWS_CNT_1;
		end

		// Falling edge: present next bit; end after eight
		if (fall) begin
			r_d.so = r_q.sr[TWS_SR_W-1];
			if (done_ev) begin
				r_d.busy   = 1'b0;
				r_d.irq_st = 1'b1;
			end
		end

		// Slave stays engaged past busy until the port leaves slave
		if (!slave_en)
			r_d.engaged = 1'b0;

		// Register writes
		if (wr_b0) begin
			case (avs_address)
				TWS_OFF_CTRL: r_d.ctrl = wb[TWS_CTRL_SEL:0];
				TWS_OFF_STAT: begin
					if (wb[TWS_STAT_BUSY]) begin
						r_d.busy = 1'b1;
						r_d.cnt  = '0;
						r_d.engaged = slave_en || r_q.engaged;
					end else begin
						r_d.busy = 1'b0;
					end
				end
				TWS_OFF_DATA: begin
					// Safe only with the clock low
					r_d.sr = wb;
					r_d.so = wb[TWS_SR_W-1];
				end
				TWS_OFF_PDAT: r_d.pdat = wb[TWS_PIN_SK:TWS_PIN_DO];
				TWS_OFF_PCFG: r_d.pcfg = wb[TWS_PIN_SK:TWS_PIN_DO];
				TWS_OFF_IRQS: begin
					// Write one clears, a done in the same cycle wins
					if (wb[TWS_IRQ_DONE] && !done_ev)
						r_d.irq_st = 1'b0;
				end
				TWS_OFF_IRQM: r_d.irq_mask = wb[TWS_IRQ_DONE];
				default: ;
			endcase
		end

		// A finished or stopped transfer launches no further rising clock edge;
		// at rate 00 the done cycle would otherwise toggle once more
		if (!r_d.busy)
			r_d.sck = 1'b0;

		// Read data captured in the wait cycle; unmapped reads zero
		if (rd_go) begin
			r_d.rdata = '0;
			case (avs_address)
				TWS_OFF_CTRL: r_d.rdata[TWS_CTRL_SEL:0] = r_q.ctrl;
				TWS_OFF_STAT: r_d.rdata[TWS_STAT_BUSY] = r_q.busy;
				TWS_OFF_DATA: r_d.rdata[TWS_SR_W-1:0] = r_q.sr;
				TWS_OFF_PDAT: r_d.rdata[TWS_PIN_SK:0] = r_q.pdat;
				TWS_OFF_PCFG: r_d.rdata[TWS_PIN_SK:0] = r_q.pcfg;
				TWS_OFF_IRQS: r_d.rdata[TWS_IRQ_DONE] = r_q.irq_st;
				TWS_OFF_IRQM: r_d.rdata[TWS_IRQ_DONE] = r_q.irq_mask;
				TWS_OFF_PINS: begin
					r_d.rdata[TWS_PIN_DO] = port_pin_data_out_o;
					r_d.rdata[TWS_PIN_SK] = port_pin_shift_clk_i;
					r_d.rdata[TWS_PIN_DI] = port_pin_data_in_i;
				end
				default: ;
			endcase
		end

		// Mode state for status and debug
		case (1'b1)
			master && r_d.busy:   r_d.st = TWS_ST_MASTER;
			slave_en && r_d.engaged: r_d.st = TWS_ST_SLAVE;
			default:              r_d.st = TWS_ST_IDLE;
		endcase

		// Pin routing: serial use only while selected
		r_d.pins.do_oe = r_d.pcfg[TWS_PIN_DO];
		r_d.pins.sk_oe = r_d.pcfg[TWS_PIN_SK];
		if (r_d.ctrl[TWS_CTRL_SEL]) begin
			r_d.pins.do_val = r_d.so;
			r_d.pins.sk_val = r_d.sck;
		end else begin
			r_d.pins.do_val = r_d.pdat[TWS_PIN_DO];
			r_d.pins.sk_val = r_d.pdat[TWS_PIN_SK];
		end
	end

	// Single state register; reset floats every pin
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			r_q <= TWS_REGS_RESET;
		else
			r_q <= r_d;
	end

endmodule

//--- tws_shifter_chk.sv
module tws_shifter_chk
	import tws_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic        port_pin_data_out_o,
	input wire logic        port_pin_data_out_oe_o,
	input wire logic        port_pin_shift_clk_o,
	input wire logic        port_pin_shift_clk_oe_o,
	input wire logic        irq_o
);
	logic       sk, skoe, wr, rise;
	logic       sel_q;
	logic [1:0] rate_q;
	logic [3:0] hi_q, rise_q;
	assign sk = port_pin_shift_clk_o;
	assign skoe = port_pin_shift_clk_oe_o;
	assign wr = avs_write && !avs_waitrequest;
	assign rise = sk && skoe && sel_q && hi_q == 4'h0;
	// Rate as written, high-phase length, master rises since last start
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rate_q <= 2'h0;
			sel_q <= 1'b0;
			hi_q <= 4'h0;
			rise_q <= 4'h0;
		end else begin
			if (wr && avs_address == TWS_OFF_CTRL) begin
				rate_q <= avs_writedata[1:0];
				sel_q <= avs_writedata[TWS_CTRL_SEL];
			end
			hi_q <= sk ? hi_q + 4'h1 : 4'h0;
			if (wr && avs_address == TWS_OFF_STAT)
				rise_q <= 4'h0;
			else if (rise)
				rise_q <= rise_q + 4'h1;
		end
	end
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	AST_BUS_WAIT:
	assert property (($rose(avs_read) || $rose(avs_write))
		|-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait");
	AST_RST_FLOAT:
	assert property ($past(rst_i) |-> !(port_pin_data_out_oe_o || skoe ||
		irq_o)) else $error("pins or irq active after reset");
	AST_RATE:
	assert property ($fell(sk) && skoe && sel_q |->
		hi_q == (rate_q == 2'h0 ? 4'h1 :
		rate_q == 2'h1 ? 4'h2 : 4'h4)) else $error("shift clock half");
	AST_DO_FALL:
	assert property ($changed(port_pin_data_out_o) && skoe &&
		!$past(avs_write) && !$past(avs_write, 2) |->
		$past(sk, 2) && !$past(sk))
		else $error("data out moved off falling edge");
	AST_DO_OE:
	assert property ($rose(port_pin_data_out_oe_o) |-> $past(avs_write, 2)
		|| $past(avs_write, 3)) else $error("data out drive unasked");
	AST_SK_OE:
	assert property ($rose(skoe) |-> $past(avs_write, 2) ||
		$past(avs_write, 3)) else $error("clock drive unasked");
	AST_RISES:
	assert property (rise |-> rise_q < 4'h8) else $error("ninth rise");
	AST_IRQ_FALL:
	assert property ($fell(irq_o) |-> $past(avs_write) ||
		$past(avs_write, 2)) else $error("irq dropped by itself");
endmodule

bind tws_shifter tws_shifter_chk chk (.*);

//--- tws_peer.sv
module tws_peer (
	input  wire logic       core_clk_i,
	input  wire logic       sk_i,
	input  wire logic       sdo_i,
	input  wire logic       fall_i,
	input  wire logic [7:0] tx_i,
	input  wire logic       load_i,
	output logic            sdi_o,
	output logic [7:0]      rx_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] tx_q;
	logic       sk_q;
	assign sdi_o = tx_q[7];
	// Block as master samples as it launches the rise, so our next bit
	// may only follow the rise; with our own clock it follows the fall
	always_ff @(posedge core_clk_i) begin
		sk_q <= sk_i;
		if (load_i)
			tx_q <= tx_i;
		else if (fall_i ? sk_q && !sk_i : !sk_q && sk_i)
			tx_q <= {tx_q[6:0], !tx_q[0]}; // Filler keeps toggling
		if (!sk_q && sk_i)
			rx_o <= {rx_o[6:0], sdo_i};
	end
endmodule

//--- tb.sv
module tb
	import tws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, exp_q[$];
	logic        avs_waitrequest, port_pin_data_out_o, port_pin_data_out_oe_o;
	logic        port_pin_shift_clk_i, port_pin_shift_clk_o, irq_o;
	logic        port_pin_shift_clk_oe_o, port_pin_data_in_i;
	logic        tb_sk = 1'b0, p_ld = 1'b0;
	logic [7:0]  p_tx = 8'h00, p_rx, tx, b;
	int          n_mismatch = 0, samples_checked = 0, per;
	tws_shifter uut (.*);
	tws_peer peer (.core_clk_i(core_clk_i), .sk_i(port_pin_shift_clk_i),
		.sdo_i(port_pin_data_out_o), .fall_i(!port_pin_shift_clk_oe_o),
		.tx_i(p_tx), .load_i(p_ld), .sdi_o(port_pin_data_in_i), .rx_o(p_rx));
	// Clock pin level: block drives it as master, the bench as slave
	assign port_pin_shift_clk_i = port_pin_shift_clk_oe_o ?
		port_pin_shift_clk_o : tb_sk;
	initial
		forever #5 core_clk_i = ~core_clk_i;
	task automatic check(input string nm, input logic [31:0] got, e);
		samples_checked++;
		if (got !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, got);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge core_clk_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge core_clk_i);
		while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic load(input logic [7:0] v);
		p_tx <= v;
		p_ld <= 1'b1;
		@(posedge core_clk_i);
		p_ld <= 1'b0;
	endtask
	// Bench is the slave's master; clock stands low between frames
	task automatic pulse(input int n);
		repeat (n) begin
			repeat (4) @(posedge core_clk_i);
			tb_sk <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			tb_sk <= 1'b0;
		end
		repeat (4) @(posedge core_clk_i);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Read data is compared in issue order at the answering edge
	always @(posedge core_clk_i)
		if (avs_read && avs_waitrequest === 1'b0)
			check("readdata", avs_readdata, exp_q.pop_front());
	// Watchdog: about seventeen times the expected run
	initial begin
		#100000;
		n_mismatch++;
		end_sim;
	end
	initial begin
		void'($urandom(97));
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(TWS_OFF_CTRL, 32'h0);
		rd(TWS_OFF_STAT, 32'h0);
		rd(TWS_OFF_PCFG, 32'h0);
		rd(5'h1E, 32'h0);
		$display("test reset done");
		// Master at every rate code; irq unmasked on odd codes only
		for (int r = 0; r < 4; r++) begin
			per = (r == 0) ? 2 : (r == 1) ? 4 : 8;
			tx = $urandom;
			b = $urandom;
			wr(TWS_OFF_CTRL, 32'h4 | r);
			wr(TWS_OFF_PCFG, 32'h3);
			wr(TWS_OFF_IRQM, r % 2);
			wr(TWS_OFF_DATA, tx);
			load(b);
			wr(TWS_OFF_STAT, 32'h1);
			repeat (8 * per + 8) @(posedge core_clk_i);
			check("irq", irq_o, r % 2);
			rd(TWS_OFF_STAT, 32'h0);
			rd(TWS_OFF_DATA, b);
			check("peer_rx", p_rx, tx);
			rd(TWS_OFF_IRQS, 32'h1);
			wr(TWS_OFF_IRQS, 32'h1);
			rd(TWS_OFF_IRQS, 32'h0);
			check("irq_clr", irq_o, 32'h0);
			$display("test master rate %0d done", r);
		end
		// Busy cleared a few cycles in: clock stops low, no done flag
		wr(TWS_OFF_CTRL, 32'h4);
		wr(TWS_OFF_STAT, 32'h1);
		wr(TWS_OFF_STAT, 32'h0);
		repeat (40) @(posedge core_clk_i);
		check("sk", port_pin_shift_clk_o, 32'h0);
		rd(TWS_OFF_IRQS, 32'h0);
		$display("test abort done");
		// Slave: shifting carries on after busy clears
		wr(TWS_OFF_PCFG, 32'h1);
		wr(TWS_OFF_DATA, tx);
		b = $urandom;
		load(b);
		wr(TWS_OFF_STAT, 32'h1);
		pulse(8);
		rd(TWS_OFF_STAT, 32'h0);
		rd(TWS_OFF_DATA, b);
		check("peer_rx", p_rx, tx);
		tx = b;
		b = $urandom;
		load(b);
		pulse(8);
		rd(TWS_OFF_DATA, b);
		check("peer_rx", p_rx, tx);
		rd(TWS_OFF_IRQS, 32'h1);
		$display("test slave done");
		// Port mode: pins follow the port data bits, serial use off
		wr(TWS_OFF_CTRL, 32'h0);
		wr(TWS_OFF_PCFG, 32'h3);
		load(8'h00);
		wr(TWS_OFF_PDAT, 32'h3);
		check("pin_oe", {port_pin_shift_clk_oe_o,
			port_pin_data_out_oe_o}, 32'h3);
		rd(TWS_OFF_PINS, 32'h3);
		wr(TWS_OFF_PDAT, 32'h0);
		rd(TWS_OFF_PINS, 32'h0);
		$display("test port done");
		end_sim;
	end
endmodule
